// ### rtl/scp_map.svh
// register map, field positions and reset values of the serial control port
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// mode register, the only register held inside this block
`define SCP_MODE_ADDR 7'h00
`define SCP_MODE_CHAIN_BIT 7
`define SCP_MODE_REL_BIT 6
`define SCP_MODE_PART_HI 5
`define SCP_MODE_PART_LO 4
`define SCP_MODE_REV_HI 3
`define SCP_MODE_REV_LO 0
`define SCP_MODE_CHAIN_RST 1'b0
`define SCP_MODE_REL_RST 1'b0

// command/address byte layout
`define SCP_CMD_DIR_BIT 7
`define SCP_CMD_READ 1'b1

// framing
`define SCP_BYTE_LAST 3'h7

`endif

// ### rtl/scp_pkg.sv
// types of the serial control port
`default_nettype none

package scp_pkg;

  // which byte of an access is being received
  typedef enum logic [1:0] {
    SCP_PH_SEL,
    SCP_PH_CMD,
    SCP_PH_DATA
  } scp_phase_t;

endpackage : scp_pkg

`default_nettype wire

// ### rtl/scp_sync.sv
// two-stage synchroniser with edge detection for pin inputs
`default_nettype none

module scp_sync #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // asynchronous pins
  input wire logic [W-1:0] pin_in,
  // synchronised level and one-cycle edge pulses
  output logic [W-1:0] lvl_out,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);

  if (W < 1) begin : g_chk
    $error("scp_sync: width must be at least one");
  end

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // idle pins read high so no false edge appears out of reset
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign lvl_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
  assign fall_out = ~sync_q & prev_q;

endmodule : scp_sync

`default_nettype wire

// ### rtl/scp_top.sv
// serial control port: four-wire register access with optional daisy chain
`include "scp_map.svh"
`default_nettype none

// Notes on behaviour
// - each access is a command/address byte then one data byte
// - top bit of command byte: 1 means read, 0 means write
// - low seven bits of the command byte address the register
// - select falling edge restarts bit framing and drops a broken byte
// - read data byte is driven out on sdo, most significant bit first
// - sdo release after a read follows the release select bit (bit 6)
// - release bit 0: float on the first falling clock edge after the last bit; 1: on select rise
// - serial input is ignored during the data byte of a read
// - sdo stays floating for the whole of a write access, except after a read in the same select with release bit 1
// - data changes on falling clock edges, sampled on rising edges
// - up to eight chained devices share one select line
// - chain mode adds a leading chip-select byte to every access
// - chain device uses select byte lsb, forwards byte shifted right
// - during the select byte chain output is sdi one clock late
// - command and data bytes pass down the chain unaltered
// - indirect registers go through direct addresses 28 to 31

module scp_top
  import scp_pkg::*;
#(
  parameter logic [1:0] PART_NUMBER = 2'h0, // arbitrary value
  parameter logic [3:0] REVISION = 4'h1 // arbitrary value
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // serial pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  output logic chain_data_out,
  // register file behind the port
  output logic [6:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [7:0] reg_rdata_in,
  // mode bits for the rest of the device
  output logic chain_mode_enable_out,
  output logic sdo_release_select_out
);

  import scp_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;

  scp_sync #(
    .W(3)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .pin_in({sdi_in, cs_n_in, sclk_in}),
    .lvl_out(pin_lvl),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  logic sdi_s;
  logic cs_low;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  assign sdi_s = pin_lvl[2];
  assign cs_low = ~pin_lvl[1];
  assign cs_fall = pin_fall[1];
  assign cs_rise = pin_rise[1];
  assign sck_rise = pin_rise[0] & cs_low;
  assign sck_fall = pin_fall[0] & cs_low;

  // ****************************************************************
  // framing and register access
  // ****************************************************************
  scp_phase_t phase_q, phase_d;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] rx_next;
  logic rd_q, rd_d;
  logic sel_q, sel_d;
  logic last_sdi_q, last_sdi_d;
  logic chain_en_q, chain_en_d;
  logic rel_sel_q, rel_sel_d;
  logic [7:0] tx_q, tx_d;
  logic rd_done_q, rd_done_d;
  logic sdo_q, sdo_d;
  logic sdo_oe_q, sdo_oe_d;
  logic chain_q, chain_d;
  logic [6:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic wr_q, wr_d;
  logic rdp_q, rdp_d;
  logic [7:0] mode_val;
  scp_phase_t first_phase;

  assign rx_next = {rx_q[6:0], sdi_s};
  assign first_phase = chain_en_q ? SCP_PH_SEL : SCP_PH_CMD;
  assign mode_val = {chain_en_q, rel_sel_q, PART_NUMBER, REVISION};

  always_comb begin
    phase_d = phase_q;
    bit_cnt_d = bit_cnt_q;
    rx_d = rx_q;
    rd_d = rd_q;
    sel_d = sel_q;
    last_sdi_d = last_sdi_q;
    chain_en_d = chain_en_q;
    rel_sel_d = rel_sel_q;
    tx_d = tx_q;
    rd_done_d = rd_done_q;
    sdo_d = sdo_q;
    sdo_oe_d = sdo_oe_q;
    chain_d = sdi_s;
    addr_d = addr_q;
    wdata_d = wdata_q;
    wr_d = 1'b0;
    rdp_d = 1'b0;
    // external register answers in the cycle of the read strobe
    if (rdp_q) begin
      tx_d = reg_rdata_in;
    end
    if (phase_q == SCP_PH_SEL) begin
      chain_d = chain_q;
      if (sck_fall) begin
        chain_d = last_sdi_q;
      end
    end
    if (cs_fall) begin
      bit_cnt_d = 3'h0;
      // a byte cut short is a framing error: restart the access
      if (bit_cnt_q != 3'h0) begin
        phase_d = first_phase;
      end
      if (first_phase == SCP_PH_SEL && (bit_cnt_q != 3'h0 || phase_q == SCP_PH_SEL)) begin
        chain_d = 1'b0;
        last_sdi_d = 1'b0;
      end
    end else if (sck_rise) begin
      rx_d = rx_next;
      last_sdi_d = sdi_s;
      bit_cnt_d = bit_cnt_q + 3'h1;
      if (bit_cnt_q == `SCP_BYTE_LAST) begin
        unique case (phase_q)
          SCP_PH_SEL: begin
            sel_d = rx_next[0];
            phase_d = SCP_PH_CMD;
          end
          SCP_PH_CMD: begin
            rd_d = (rx_next[`SCP_CMD_DIR_BIT] == `SCP_CMD_READ);
            addr_d = rx_next[6:0];
            phase_d = SCP_PH_DATA;
            if (rx_next[`SCP_CMD_DIR_BIT] == `SCP_CMD_READ && sel_q) begin
              if (rx_next[6:0] == `SCP_MODE_ADDR) begin
                tx_d = mode_val;
              end else begin
                rdp_d = 1'b1;
              end
            end
          end
          SCP_PH_DATA: begin
            phase_d = first_phase;
            if (!chain_en_q) begin
              sel_d = 1'b1;
            end
            if (rd_q) begin
              rd_done_d = sel_q;
            end else if (sel_q) begin
              if (addr_q == `SCP_MODE_ADDR) begin
                chain_en_d = rx_next[`SCP_MODE_CHAIN_BIT];
                rel_sel_d = rx_next[`SCP_MODE_REL_BIT];
                // the next access must already be framed by the new chain setting
                phase_d = rx_next[`SCP_MODE_CHAIN_BIT] ? SCP_PH_SEL : SCP_PH_CMD;
              end else begin
                wr_d = 1'b1;
                wdata_d = rx_next;
              end
            end
          end
          default: begin
            phase_d = first_phase;
          end
        endcase
      end
    end else if (sck_fall) begin
      if (phase_q == SCP_PH_DATA && rd_q && sel_q) begin
        sdo_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
        sdo_oe_d = 1'b1;
      end else if (rd_done_q && !rel_sel_q) begin
        sdo_oe_d = 1'b0;
        rd_done_d = 1'b0;
      end
    end
    if (cs_rise) begin
      sdo_oe_d = 1'b0;
      rd_done_d = 1'b0;
    end
    if (phase_q != SCP_PH_DATA && phase_d == SCP_PH_DATA && !chain_en_q) begin
      sel_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      phase_q <= SCP_PH_CMD;
      bit_cnt_q <= 3'h0;
      rx_q <= 8'h00;
      rd_q <= 1'b0;
      sel_q <= 1'b1;
      last_sdi_q <= 1'b0;
      chain_en_q <= `SCP_MODE_CHAIN_RST;
      rel_sel_q <= `SCP_MODE_REL_RST;
      tx_q <= 8'h00;
      rd_done_q <= 1'b0;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
      chain_q <= 1'b0;
      addr_q <= 7'h00;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rdp_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      bit_cnt_q <= bit_cnt_d;
      rx_q <= rx_d;
      rd_q <= rd_d;
      sel_q <= sel_d;
      last_sdi_q <= last_sdi_d;
      chain_en_q <= chain_en_d;
      rel_sel_q <= rel_sel_d;
      tx_q <= tx_d;
      rd_done_q <= rd_done_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
      chain_q <= chain_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      wr_q <= wr_d;
      rdp_q <= rdp_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign sdo_out = sdo_q;
  assign sdo_oe_out = sdo_oe_q;
  assign chain_data_out = chain_q;
  assign reg_addr_out = addr_q;
  assign reg_wdata_out = wdata_q;
  assign reg_wr_out = wr_q;
  assign reg_rd_out = rdp_q;
  assign chain_mode_enable_out = chain_en_q;
  assign sdo_release_select_out = rel_sel_q;

endmodule : scp_top

`default_nettype wire

// ### verif/scp_monitor.sv
// concurrent checks on the serial control port
`default_nettype none
module scp_monitor (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // serial pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_out,
  input wire logic chain_data_out,
  // register side and mode
  input wire logic [6:0] reg_addr_out,
  input wire logic [7:0] reg_wdata_out,
  input wire logic reg_wr_out,
  input wire logic reg_rd_out,
  input wire logic [7:0] reg_rdata_in,
  input wire logic chain_mode_enable_out,
  input wire logic sdo_release_select_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in);
  endclocking
  default disable iff (srst_in);
  a_wr_single: assert property (reg_wr_out |=> !reg_wr_out [*8])
    else $error("write strobe repeated");
  a_wr_addr: assert property (reg_wr_out |-> reg_addr_out != 7'h00 && !reg_rd_out)
    else $error("write strobe on mode address");
  a_rd_addr: assert property (reg_rd_out |-> reg_addr_out != 7'h00 ##1 !reg_rd_out)
    else $error("bad read strobe");
  a_rd_drives: assert property (reg_rd_out |-> ##[4:60] sdo_oe_out)
    else $error("read data never driven");
  a_oe_on_fall: assert property ($rose(sdo_oe_out) |-> !$past(sclk_in, 2))
    else $error("output enabled off a falling edge");
  a_sdo_on_fall: assert property ($changed(sdo_out) && sdo_oe_out |-> !$past(sclk_in, 2))
    else $error("output changed off a falling edge");
  a_sdo_hold: assert property ($rose(sclk_in) && sdo_oe_out |=> $stable(sdo_out) [*8])
    else $error("output bit not held");
  a_cs_release: assert property (cs_n_in [*6] |-> !sdo_oe_out)
    else $error("output driven with select high");
  a_mode_src: assert property (
    $changed({chain_mode_enable_out, sdo_release_select_out}) |-> reg_addr_out == 7'h00)
    else $error("mode changed without mode access");
  c_write: cover property (reg_wr_out);
  c_read: cover property ($rose(sdo_oe_out));
  c_chain: cover property (chain_mode_enable_out && reg_wr_out);
endmodule : scp_monitor
bind scp_top scp_monitor u_mon (.clk_sys_in, .srst_in, .sclk_in, .cs_n_in, .sdi_in, .sdo_out,
  .sdo_oe_out, .chain_data_out, .reg_addr_out, .reg_wdata_out, .reg_wr_out, .reg_rd_out,
  .reg_rdata_in, .chain_mode_enable_out, .sdo_release_select_out);
`default_nettype wire

// ### verif/scp_host.sv
// host model driving the serial pins, clock parked high between bytes
`default_nettype none
module scp_host (
  // clock
  input wire logic clk_sys_in,
  // serial pins
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in,
  input wire logic sdo_oe_in,
  input wire logic chain_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx,
      output logic [7:0] ch, output logic oe, input bit keep = 1'b0);
    rx = 8'h00;
    ch = 8'h00;
    oe = 1'b0;
    if (cs_n_out) begin
      cs_n_out <= 1'b0;
      repeat (8) @(posedge clk_sys_in);
    end
    for (int i = 7; i > 7 - nb; i--) begin
      sclk_out <= 1'b0;
      sdi_out <= tx[i];
      repeat (16) @(posedge clk_sys_in);
      sclk_out <= 1'b1;
      @(posedge clk_sys_in);
      // undriven line reads as the inverse of the last bit
      rx = {rx[6:0], sdo_oe_in ? sdo_in : ~rx[0]};
      ch = {ch[6:0], chain_in};
      oe = oe | sdo_oe_in;
      repeat (15) @(posedge clk_sys_in);
    end
    // sdi only moves with a falling clock, so it is left as it stands here
    if (!keep) begin
      cs_n_out <= 1'b1;
      repeat (8) @(posedge clk_sys_in);
    end
  endtask : xfer
endmodule : scp_host
`default_nettype wire

// ### verif/tb.sv
// self-checking testbench of the serial control port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] rdata = 8'h00;
  logic sclk, cs_n, sdi, sdo, sdo_oe, chn, wr, rd, cme, rel;
  logic [6:0] addr;
  logic [7:0] wdata, rx, ch, rd_b = 8'h00;
  logic oe, rd_v = 1'b0, chain_q = 1'b0, rel_q = 1'b0;
  logic [15:0] notes[$];
  int error_cnt = 0, n_tests = 0, cyc = 0, rd_exp = 0, rd_seen = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  scp_top #(.PART_NUMBER(2'h0), .REVISION(4'h1)) u_dut (.clk_sys_in, .srst_in,
    .sclk_in(sclk), .cs_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe),
    .chain_data_out(chn), .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_rdata_in(rdata), .chain_mode_enable_out(cme),
    .sdo_release_select_out(rel));
  scp_host u_host (.clk_sys_in, .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
    .sdo_in(sdo), .sdo_oe_in(sdo_oe), .chain_in(chn));
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // one access; unselected chain devices expect no result
  task automatic acc(input logic [7:0] s, c, d, input bit keep = 1'b0);
    logic on;
    on = !chain_q || s[0];
    if (chain_q) begin
      u_host.xfer(s, 8, rx, ch, oe);
      check("chain select", {8'h00, s >> 1}, {8'h00, ch});
    end
    u_host.xfer(c, 8, rx, ch, oe);
    check("cmd oe", 16'h0, {15'h0, oe});
    if (chain_q) check("chain cmd", {8'h00, c}, {8'h00, ch});
    if (on && c[7]) notes.push_back({8'h80, c[6:0] ? rdata : {chain_q, rel_q, 6'h01}});
    if (on && c[7] && c[6:0] != 7'h00) rd_exp++;
    if (on && !c[7] && c[6:0] != 7'h00) notes.push_back({1'b0, c[6:0], d});
    u_host.xfer(c[7] ? 8'($urandom) : d, 8, rx, ch, oe, keep);
    if (!c[7]) check("write oe", 16'h0, {15'h0, oe});
    if (chain_q && !c[7]) check("chain data", {8'h00, d}, {8'h00, ch});
    if (on && c[7]) begin
      rd_b <= rx;
      rd_v <= 1'b1;
      @(posedge clk_sys_in);
      rd_v <= 1'b0;
    end
    if (on && c == 8'h00) begin
      chain_q = d[7];
      rel_q = d[6];
      check("mode", {14'h0, d[7:6]}, {14'h0, cme, rel});
    end
  endtask : acc
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
    if (rd) rd_seen <= rd_seen + 1;
    if (wr || rd_v) begin
      check("result", notes.size() ? notes.pop_front() : 16'hxxxx,
        wr ? {1'b0, addr, wdata} : {8'h80, rd_b});
    end
  end
  initial begin
    void'($urandom(32'h6994));
    repeat (4) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    check("reset mode", 16'h0, {14'h0, cme, rel});
    for (int i = 0; i < 4; i++) acc(8'h01, {5'h03, 2'($urandom)}, 8'($urandom));
    acc(8'h01, 8'h6b, 8'h5a);
    for (int i = 0; i < 3; i++) begin
      rdata <= 8'($urandom);
      acc(8'h01, {1'b1, 7'($urandom_range(127, 1))}, 8'h00);
    end
    acc(8'h01, 8'h80, 8'h00);
    // broken byte, then a clean access must still frame right
    u_host.xfer(8'hff, 3, rx, ch, oe);
    acc(8'h01, 8'h1c, 8'h3c);
    acc(8'h01, 8'h85, 8'h00, 1'b1);
    acc(8'h01, 8'h09, 8'h11);
    acc(8'h01, 8'h00, 8'h40);
    acc(8'h01, 8'h9e, 8'h00);
    acc(8'h01, 8'h00, 8'hc0);
    acc(8'h01, 8'h21, 8'h77);
    acc(8'h06, 8'h22, 8'h88);
    acc(8'h81, 8'h95, 8'h00);
    acc(8'h01, 8'h80, 8'h00);
    acc(8'h01, 8'h00, 8'h00);
    repeat (8) @(posedge clk_sys_in);
    check("left over", 16'h0, 16'(notes.size()));
    check("read strobes", 16'(rd_exp), 16'(rd_seen));
    conclude();
  end
endmodule : tb
`default_nettype wire
